//--- rtl/pdam_core.sv
// Module: program and data address map of a 16-bit core
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Program addresses are 24 bits, from 23-bit pointer or table path.
// - User access stays in lower half; page bit 7 lets table ops above.
// - Each location: lower word even, upper word odd, top byte zero.
// - Pointer stays word aligned, steps by two up or down.
// - After reset fetching starts at zero; jump target sits at two.
// - Addresses 0 to 1FFh are reserved vectors, two tables of 256.
// - Top three program words hold configuration.
// - Each reset copies configuration words into configuration registers.
// - Data space is 16 bits wide with separate read and write generators.
// - Effective addresses are 16-bit byte addresses, 64 KB range.
// - Top address bit clear is RAM space, set is program window.
// - 16 KB data memory; reads outside return zero.
// - Low byte at even address, high byte at odd address.
// - Post-modify step is one for bytes, two for words.
// - Byte reads select byte by bit zero onto low lane.
// - Byte writes enable only the matching lane.
// - Odd word access traps; reads complete, writes are suppressed.
// - Byte load into working register changes only its low byte.
// - Sign extend byte to word, or clear upper byte.
// - Memory-direct uses 13-bit near field; transfer uses full 16 bits.
// - Special registers occupy 0 to 7FFh; unimplemented ones read zero.
module pdam_core
  import pdam_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Instruction pointer control
  input wire logic ip_step_i,
  input wire logic ip_down_i,
  input wire logic ip_load_i,
  input wire logic [22:0] ip_target_i,
  output logic [23:0] instruction_pointer_o,
  output logic boot_done_o,
  // Program memory port
  output logic [23:0] prog_addr_o,
  input wire logic [23:0] prog_rdata_i,
  output logic prog_upper_o,
  output logic prog_denied_o,
  // Table access
  input wire pdam_tbl_req_type tbl_req_i,
  output logic [15:0] tbl_rdata_o,
  // Configuration registers
  output logic [23:0] cfg_word0_o,
  output logic [23:0] cfg_word1_o,
  output logic [23:0] cfg_word2_o,
  // Data read and write generators
  input wire pdam_data_req_type rd_req_i,
  input wire pdam_data_req_type wr_req_i,
  output logic [15:0] rd_data_o,
  output logic [15:0] rd_addr_next_o,
  output logic [15:0] wr_addr_next_o,
  output logic addr_error_o,
  // Program window read
  output logic psv_req_o,
  output logic [14:0] psv_addr_o,
  input wire logic [15:0] psv_rdata_i,
  // Special register sideband
  input wire logic [PDAM_SFR_WORDS-1:0] sfr_impl_i,
  input wire logic [15:0] sfr_rdata_i,
  output logic [1:0] sfr_we_o,
  output logic [15:0] sfr_addr_o,
  output logic [15:0] sfr_wdata_o,
  // Working register byte/extend helpers
  input wire logic [15:0] wreg_old_i,
  input wire logic [7:0] wreg_byte_i,
  input wire logic wreg_byte_load_i,
  input wire pdam_reg_op_type wreg_op_i,
  output logic [15:0] wreg_new_o
);

  ////////////////////////////////////////////////////////////////////////
  // Boot and instruction pointer
  pdam_state_type state_reg, state_next;
  logic [23:0] ip_reg, ip_next;
  logic [23:0] cfg_reg [PDAM_CFG_WORDS], cfg_next [PDAM_CFG_WORDS];
  logic [23:0] boot_addr;

  always_comb begin
    state_next = state_reg;
    ip_next = ip_reg;
    for (int k = 0; k < PDAM_CFG_WORDS; k++) begin
      cfg_next[k] = cfg_reg[k];
    end
    boot_addr = PDAM_CFG_ADDR_FIRST;
    case (state_reg)
      PDAM_ST_CFG0: begin
        boot_addr = PDAM_CFG_ADDR_FIRST;
        cfg_next[0] = prog_rdata_i;
        state_next = PDAM_ST_CFG1;
      end
      PDAM_ST_CFG1: begin
        boot_addr = PDAM_CFG_ADDR_FIRST + PDAM_ADDR_STEP;
        cfg_next[1] = prog_rdata_i;
        state_next = PDAM_ST_CFG2;
      end
      PDAM_ST_CFG2: begin
        boot_addr = PDAM_CFG_ADDR_LAST;
        cfg_next[2] = prog_rdata_i;
        state_next = PDAM_ST_RUN;
      end
      PDAM_ST_RUN: begin
        if (ip_load_i) begin
          ip_next = {1'b0, ip_target_i[22:1], 1'b0};
        end else if (ip_step_i && ip_down_i) begin
          ip_next = ip_reg - PDAM_ADDR_STEP;
        end else if (ip_step_i) begin
          ip_next = ip_reg + PDAM_ADDR_STEP;
        end
        ip_next[0] = 1'b0;
        ip_next[PDAM_USER_TOP_BIT] = 1'b0;
      end
      default: state_next = PDAM_ST_CFG0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= PDAM_ST_CFG0;
      ip_reg <= PDAM_RESET_ADDR;
      for (int k = 0; k < PDAM_CFG_WORDS; k++) begin
        cfg_reg[k] <= PDAM_CFG_RESET;
      end
    end else begin
      state_reg <= state_next;
      ip_reg <= ip_next;
      for (int k = 0; k < PDAM_CFG_WORDS; k++) begin
        cfg_reg[k] <= cfg_next[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program address path
  logic [23:0] tbl_addr;
  logic tbl_active, tbl_denied;

  assign tbl_addr = {tbl_req_i.table_page_reg, tbl_req_i.offset};
  assign tbl_active = tbl_req_i.valid &&
    (tbl_req_i.table_read_op || tbl_req_i.table_write_op);
  assign tbl_denied = tbl_active &&
    !tbl_req_i.table_page_reg[PDAM_TBLPAGE_HI_BIT] &&
    tbl_addr[PDAM_USER_TOP_BIT];

  always_comb begin
    if (state_reg != PDAM_ST_RUN) begin
      prog_addr_o = boot_addr;
    end else if (tbl_active && !tbl_denied) begin
      prog_addr_o = tbl_addr;
    end else if (psv_req_o) begin
      prog_addr_o = {9'h000, psv_addr_o};
    end else begin
      prog_addr_o = ip_reg;
    end
  end

  assign prog_upper_o = tbl_active && tbl_addr[0];
  always_comb begin
    if (tbl_addr[0]) begin
      tbl_rdata_o = {8'h00, prog_rdata_i[23:16]};
    end else begin
      tbl_rdata_o = prog_rdata_i[15:0];
    end
  end
  assign prog_denied_o = tbl_denied;
  assign instruction_pointer_o = ip_reg;
  assign boot_done_o = (state_reg == PDAM_ST_RUN);
  assign cfg_word0_o = cfg_reg[0];
  assign cfg_word1_o = cfg_reg[1];
  assign cfg_word2_o = cfg_reg[2];

  ////////////////////////////////////////////////////////////////////////
  // Data space decode
  logic [15:0] ram_mem [PDAM_RAM_WORDS];
  logic [15:0] rd_ea, wr_ea, rd_word, rd_word_reg;
  logic rd_in_ram, wr_in_ram, rd_in_sfr, wr_in_sfr, rd_in_psv;
  logic rd_sfr_impl, wr_sfr_impl, rd_misalign, wr_misalign;
  logic [1:0] wr_lanes;
  logic rd_byte_reg, rd_sel_reg, rd_hit_reg, rd_psv_reg, rd_sfr_reg;
  logic addr_error_reg;

  // Near field masks to 13 bits
  assign rd_ea = rd_req_i.near_mode ?
    (rd_req_i.effective_byte_address & PDAM_NEAR_MASK) :
    rd_req_i.effective_byte_address;
  assign wr_ea = wr_req_i.near_mode ?
    (wr_req_i.effective_byte_address & PDAM_NEAR_MASK) :
    wr_req_i.effective_byte_address;

  // Top bit splits RAM and window
  assign rd_in_psv = rd_ea[PDAM_PSV_BIT];
  assign rd_in_sfr = !rd_in_psv && (rd_ea <= PDAM_SFR_LAST);
  assign wr_in_sfr = !wr_ea[PDAM_PSV_BIT] && (wr_ea <= PDAM_SFR_LAST);
  assign rd_in_ram = !rd_in_sfr && (rd_ea < PDAM_RAM_BYTES);
  assign wr_in_ram = !wr_in_sfr && (wr_ea < PDAM_RAM_BYTES);
  assign rd_sfr_impl = sfr_impl_i[rd_ea[10:1]];
  assign wr_sfr_impl = sfr_impl_i[wr_ea[10:1]];

  assign rd_misalign = rd_req_i.valid && !rd_req_i.byte_op && rd_ea[0];
  assign wr_misalign = wr_req_i.valid && !wr_req_i.byte_op && wr_ea[0];

  always_comb begin
    if (!wr_req_i.valid || !wr_req_i.write || wr_misalign) begin
      wr_lanes = 2'b00;
    end else if (wr_req_i.byte_op) begin
      wr_lanes = wr_ea[0] ? 2'b10 : 2'b01;
    end else begin
      wr_lanes = 2'b11;
    end
  end

  assign sfr_wdata_o = (wr_req_i.byte_op && wr_ea[0]) ?
    {wr_req_i.wdata[7:0], wr_req_i.wdata[7:0]} : wr_req_i.wdata;
  assign sfr_we_o = (wr_in_sfr && wr_sfr_impl) ? wr_lanes : 2'b00;
  assign sfr_addr_o = rd_req_i.valid ? rd_ea : wr_ea;

  always_ff @(posedge clk_i) begin
    if (wr_in_ram && wr_lanes[0]) begin
      ram_mem[wr_ea[13:1]][7:0] <= sfr_wdata_o[7:0];
    end
    if (wr_in_ram && wr_lanes[1]) begin
      ram_mem[wr_ea[13:1]][15:8] <= sfr_wdata_o[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    rd_word_reg <= ram_mem[rd_ea[13:1]];
  end

  assign psv_req_o = rd_req_i.valid && rd_in_psv;
  assign psv_addr_o = rd_ea[14:0];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_byte_reg <= 1'b0;
      rd_sel_reg <= 1'b0;
      rd_hit_reg <= 1'b0;
      rd_psv_reg <= 1'b0;
      rd_sfr_reg <= 1'b0;
      addr_error_reg <= 1'b0;
    end else begin
      rd_byte_reg <= rd_req_i.byte_op;
      rd_sel_reg <= rd_ea[0];
      rd_hit_reg <= rd_req_i.valid && rd_in_ram;
      rd_psv_reg <= rd_req_i.valid && rd_in_psv;
      rd_sfr_reg <= rd_req_i.valid && rd_in_sfr && rd_sfr_impl;
      addr_error_reg <= rd_misalign || wr_misalign;
    end
  end

  always_comb begin
    if (rd_hit_reg) begin
      rd_word = rd_word_reg;
    end else if (rd_psv_reg) begin
      rd_word = psv_rdata_i;
    end else if (rd_sfr_reg) begin
      rd_word = sfr_rdata_i;
    end else begin
      rd_word = PDAM_ZERO16;
    end
  end

  assign rd_data_o = rd_byte_reg ?
    {8'h00, (rd_sel_reg ? rd_word[15:8] : rd_word[7:0])} : rd_word;
  assign addr_error_o = addr_error_reg;

  assign rd_addr_next_o = rd_req_i.effective_byte_address +
    (rd_req_i.byte_op ? PDAM_BYTE_STEP : PDAM_WORD_STEP);
  assign wr_addr_next_o = wr_req_i.effective_byte_address +
    (wr_req_i.byte_op ? PDAM_BYTE_STEP : PDAM_WORD_STEP);

  ////////////////////////////////////////////////////////////////////////
  // Working register result
  always_comb begin
    case (wreg_op_i)
      PDAM_REG_SIGN_EXT: wreg_new_o = {{8{wreg_old_i[7]}}, wreg_old_i[7:0]};
      PDAM_REG_UPPER_CLR: wreg_new_o = {8'h00, wreg_old_i[7:0]};
      default: begin
        if (wreg_byte_load_i) begin
          wreg_new_o = {wreg_old_i[15:8], wreg_byte_i};
        end else begin
          wreg_new_o = wreg_old_i;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_ip_aligned: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ip_reg[0] == 1'b0) else $error("pointer misaligned");
  a_ip_step_two: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    boot_done_o && ip_step_i && !ip_down_i && !ip_load_i
    |=> ip_reg == $past(ip_reg) + PDAM_ADDR_STEP)
    else $error("step not two");
  a_boot_three_cyc: assert property (@(posedge clk_i)
    $rose(rst_n_i) |-> !boot_done_o ##3 boot_done_o)
    else $error("config copy length wrong");
  a_start_in_vectors: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    $rose(boot_done_o) |-> ip_reg < PDAM_VECTOR_END)
    else $error("start outside vector area");
  a_user_lower_half: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    boot_done_o && !tbl_active |-> !prog_addr_o[PDAM_USER_TOP_BIT])
    else $error("user fetch in upper half");
  a_misalign_trap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_misalign |-> wr_lanes == 2'b00 ##1 addr_error_o)
    else $error("misaligned write not trapped");
  a_byte_lane_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_req_i.byte_op |-> !(wr_lanes[0] && wr_lanes[1]))
    else $error("byte write two lanes");
  a_zero_outside: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_req_i.valid && !rd_in_ram && !rd_in_psv && !rd_in_sfr
    |=> rd_data_o == PDAM_ZERO16) else $error("outside not zero");
  a_byte_high_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_req_i.valid && rd_req_i.byte_op |=> rd_data_o[15:8] == 8'h00)
    else $error("byte read high lane");
  a_sfr_unimpl_we: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_in_sfr && !wr_sfr_impl |-> sfr_we_o == 2'b00)
    else $error("unimplemented write");
  c_boot_done: cover property (@(posedge clk_i) $rose(boot_done_o));
  c_misalign: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_misalign);
  c_psv_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    psv_req_o);
  c_tbl_cfg: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    tbl_active && tbl_req_i.table_page_reg[PDAM_TBLPAGE_HI_BIT]);
endmodule

//--- shared/pdam_pkg.sv
// Package: constants and carrier types of the program/data address map
package pdam_pkg;
  localparam int PDAM_PADDR_W = 24;
  localparam int PDAM_IP_W = 23;
  localparam int PDAM_EA_W = 16;
  localparam int PDAM_DATA_W = 16;
  localparam logic [23:0] PDAM_RESET_ADDR = 24'h00_0000;
  localparam logic [23:0] PDAM_JUMP_TARGET_ADDR = 24'h00_0002;
  localparam logic [23:0] PDAM_IVT_START = 24'h00_0004;
  localparam logic [23:0] PDAM_AIVT_START = 24'h00_0100;
  localparam logic [23:0] PDAM_AIVT_END = 24'h00_01FF;
  localparam logic [23:0] PDAM_VECTOR_END = 24'h00_0200;
  localparam logic [23:0] PDAM_CFG_ADDR_FIRST = 24'h02_ABFA;
  localparam logic [23:0] PDAM_CFG_ADDR_LAST = 24'h02_ABFE;
  localparam logic [23:0] PDAM_ADDR_STEP = 24'h00_0002;
  localparam int PDAM_CFG_WORDS = 3;
  localparam int PDAM_USER_TOP_BIT = 23;
  localparam int PDAM_TBLPAGE_HI_BIT = 7;
  localparam int PDAM_PSV_BIT = 15;
  localparam logic [15:0] PDAM_RAM_BYTES = 16'h4000;
  localparam int PDAM_RAM_WORDS = 8192;
  localparam logic [15:0] PDAM_SFR_LAST = 16'h07FF;
  localparam logic [15:0] PDAM_NEAR_MASK = 16'h1FFF;
  localparam int PDAM_SFR_WORDS = 1024;
  localparam logic [15:0] PDAM_BYTE_STEP = 16'h0001;
  localparam logic [15:0] PDAM_WORD_STEP = 16'h0002;
  localparam logic [15:0] PDAM_ZERO16 = 16'h0000;
  localparam logic [23:0] PDAM_ZERO24 = 24'h00_0000;
  localparam logic [23:0] PDAM_CFG_RESET = 24'hFF_FFFF;

  typedef enum logic [1:0] {
    PDAM_ST_CFG0 = 2'b00,
    PDAM_ST_CFG1 = 2'b01,
    PDAM_ST_CFG2 = 2'b11,
    PDAM_ST_RUN = 2'b10
  } pdam_state_type;

  typedef enum logic [1:0] {
    PDAM_REG_NONE = 2'b00,
    PDAM_REG_SIGN_EXT = 2'b01,
    PDAM_REG_UPPER_CLR = 2'b10
  } pdam_reg_op_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic byte_op;
    logic near_mode;
    logic [15:0] effective_byte_address;
    logic [15:0] wdata;
  } pdam_data_req_type;

  typedef struct packed {
    logic valid;
    logic table_read_op;
    logic table_write_op;
    logic [7:0] table_page_reg;
    logic [15:0] offset;
  } pdam_tbl_req_type;
endpackage

//--- verif/pdam_far_model.sv
// Far-side model: program array, program window and special registers
`timescale 1ns/1ps

module pdam_far_model
  import pdam_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Program array, combinational read
  input wire logic [23:0] prog_addr_i,
  output logic [23:0] prog_rdata_o,
  // Program window, data one cycle after request
  input wire logic psv_req_i,
  input wire logic [14:0] psv_addr_i,
  output logic [15:0] psv_rdata_o,
  // Special registers, data one cycle after address
  input wire logic [15:0] sfr_addr_i,
  output logic [PDAM_SFR_WORDS-1:0] sfr_impl_o,
  output logic [15:0] sfr_rdata_o
);
  logic [23:0] word_addr;

  ////////////////////////////////////////////////////////////////////////
  // Odd address selects the same location, so bit zero is ignored
  assign word_addr = {prog_addr_i[23:1], 1'b0};
  assign prog_rdata_o = {word_addr[7:0] ^ 8'h3C, word_addr[15:0] ^ 16'h5A5A};

  // Only even word indices exist, so gaps get exercised
  always_comb begin
    for (int i = 0; i < PDAM_SFR_WORDS; i++) begin
      sfr_impl_o[i] = ~i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Idle window shows inverted stale data, never a held value
  initial psv_rdata_o = 16'h0000;
  always @(posedge clk_i) begin
    if (psv_req_i) begin
      psv_rdata_o <= {1'b0, psv_addr_i} ^ 16'h0F0F;
    end else begin
      psv_rdata_o <= ~psv_rdata_o;
    end
    sfr_rdata_o <= sfr_addr_i ^ 16'hC3C3;
  end
endmodule

//--- verif/pdam_core_test.sv
// Self-checking bench of the program/data address map
`timescale 1ns/1ps

module pdam_core_test
  import pdam_pkg::*;
;
  typedef struct packed {
    logic err;
    logic chk;
    logic [15:0] data;
  } pdam_note_type;

  logic clk_i, rst_n_i, ip_step_i, ip_down_i, ip_load_i, boot_done_o;
  logic [22:0] ip_target_i;
  logic [23:0] instruction_pointer_o, prog_addr_o, prog_rdata_i;
  logic prog_upper_o, prog_denied_o, addr_error_o, psv_req_o;
  pdam_tbl_req_type tbl_req_i;
  pdam_data_req_type rd_req_i, wr_req_i;
  logic [15:0] tbl_rdata_o, rd_data_o, rd_addr_next_o, wr_addr_next_o;
  logic [23:0] cfg_word0_o, cfg_word1_o, cfg_word2_o;
  logic [14:0] psv_addr_o;
  logic [15:0] psv_rdata_i, sfr_rdata_i, sfr_addr_o, sfr_wdata_o;
  logic [15:0] wreg_old_i, wreg_new_o, rw;
  logic [PDAM_SFR_WORDS-1:0] sfr_impl_i;
  logic [1:0] sfr_we_o;
  logic [7:0] wreg_byte_i;
  logic wreg_byte_load_i, rd_v_q, wr_v_q;
  pdam_reg_op_type wreg_op_i;
  pdam_note_type notes[$];
  pdam_note_type note;
  int miscompares, total_checks, cycles;
  integer seed;

  pdam_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ip_step_i(ip_step_i),
    .ip_down_i(ip_down_i), .ip_load_i(ip_load_i), .ip_target_i(ip_target_i),
    .instruction_pointer_o(instruction_pointer_o), .boot_done_o(boot_done_o),
    .prog_addr_o(prog_addr_o), .prog_rdata_i(prog_rdata_i),
    .prog_upper_o(prog_upper_o), .prog_denied_o(prog_denied_o),
    .tbl_req_i(tbl_req_i), .tbl_rdata_o(tbl_rdata_o),
    .cfg_word0_o(cfg_word0_o), .cfg_word1_o(cfg_word1_o),
    .cfg_word2_o(cfg_word2_o), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
    .rd_data_o(rd_data_o), .rd_addr_next_o(rd_addr_next_o),
    .wr_addr_next_o(wr_addr_next_o), .addr_error_o(addr_error_o),
    .psv_req_o(psv_req_o), .psv_addr_o(psv_addr_o),
    .psv_rdata_i(psv_rdata_i), .sfr_impl_i(sfr_impl_i),
    .sfr_rdata_i(sfr_rdata_i), .sfr_we_o(sfr_we_o), .sfr_addr_o(sfr_addr_o),
    .sfr_wdata_o(sfr_wdata_o), .wreg_old_i(wreg_old_i),
    .wreg_byte_i(wreg_byte_i), .wreg_byte_load_i(wreg_byte_load_i),
    .wreg_op_i(wreg_op_i), .wreg_new_o(wreg_new_o));

  pdam_far_model far_u (.clk_i(clk_i), .prog_addr_i(prog_addr_o),
    .prog_rdata_o(prog_rdata_i), .psv_req_i(psv_req_o),
    .psv_addr_i(psv_addr_o), .psv_rdata_o(psv_rdata_i),
    .sfr_addr_i(sfr_addr_o), .sfr_impl_o(sfr_impl_i),
    .sfr_rdata_o(sfr_rdata_i));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] pm(input logic [23:0] a);
    return {a[7:0] ^ 8'h3C, a[15:0] ^ 16'h5A5A};
  endfunction

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check_val(boot_done_o, 1'b0);
    repeat (2) @(negedge clk_i);
    check_val(boot_done_o, 1'b1);
    check_val(cfg_word0_o, pm(24'h02_ABFA));
    check_val(cfg_word1_o, pm(24'h02_ABFC));
    check_val(cfg_word2_o, pm(24'h02_ABFE));
    check_val(instruction_pointer_o, 24'h00_0000);
  endtask

  task automatic ip_op(input logic st, input logic dn, input logic ld,
                       input logic [22:0] tg, input logic [23:0] exp);
    @(negedge clk_i);
    ip_step_i = st;
    ip_down_i = dn;
    ip_load_i = ld;
    ip_target_i = tg;
    @(negedge clk_i);
    ip_step_i = 1'b0;
    ip_load_i = 1'b0;
    check_val(instruction_pointer_o, exp);
    check_val(prog_addr_o, exp);
  endtask

  task automatic data_op(input logic wr, input logic bt, input logic nr,
                         input logic [15:0] ea, input logic [15:0] wd,
                         input logic [15:0] exp, input logic err,
                         input logic chk);
    pdam_data_req_type rq;
    logic [1:0] lanes;
    rq = '{1'b1, wr, bt, nr, ea, wd};
    @(negedge clk_i);
    rd_req_i = wr ? '0 : rq;
    wr_req_i = wr ? rq : '0;
    notes.push_back('{err, chk, exp});
    #1;
    if (!nr) check_val(wr ? wr_addr_next_o : rd_addr_next_o,
                       ea + (bt ? 16'h0001 : 16'h0002));
    lanes = bt ? (ea[0] ? 2'b10 : 2'b01) : (ea[0] ? 2'b00 : 2'b11);
    if (wr && ea <= PDAM_SFR_LAST)
      check_val(sfr_we_o, ea[1] ? 2'b00 : lanes);
  endtask

  task automatic tbl_op(input logic [7:0] pg, input logic [15:0] off,
                        input logic [15:0] exp);
    @(negedge clk_i);
    tbl_req_i = '{1'b1, 1'b1, 1'b0, pg, off};
    #1;
    check_val(tbl_rdata_o, exp);
    check_val(prog_upper_o, off[0]);
    check_val(prog_denied_o, 1'b0);
    if (!off[0]) check_val(prog_addr_o, {pg, off});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Result watcher: one note per request, judged mid answer cycle
  always @(posedge clk_i) begin
    rd_v_q <= rd_req_i.valid && rst_n_i;
    wr_v_q <= wr_req_i.valid && wr_req_i.write && rst_n_i;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  always @(negedge clk_i) begin
    if (rd_v_q || wr_v_q) begin
      if (notes.size() == 0) check_val(24'h00_0001, 24'h00_0000);
      else begin
        note = notes.pop_front();
        if (note.chk) check_val(rd_data_o, note.data);
        check_val(addr_error_o, note.err);
      end
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hcc20;
    {rst_n_i, ip_step_i, ip_down_i, ip_load_i, ip_target_i} = '0;
    {tbl_req_i, rd_req_i, wr_req_i, wreg_old_i, wreg_byte_i} = '0;
    wreg_byte_load_i = 1'b0;
    wreg_op_i = PDAM_REG_NONE;
    cycles = 0;
    do_reset();
    ip_op(1'b1, 1'b0, 1'b0, 23'h0, 24'h00_0002);
    ip_op(1'b1, 1'b1, 1'b0, 23'h0, 24'h00_0000);
    ip_op(1'b0, 1'b0, 1'b1, 23'h12_3457, 24'h12_3456);
    ip_op(1'b1, 1'b1, 1'b1, 23'h00_0101, 24'h00_0100);
    ip_op(1'b1, 1'b1, 1'b0, 23'h0, 24'h00_00FE);
    rw = $random(seed);
    // Byte lanes over a random word, then misaligned and decode cases
    data_op(1'b1, 1'b0, 1'b0, 16'h0802, rw, 16'h0, 1'b0, 1'b0);
    data_op(1'b1, 1'b1, 1'b0, 16'h0803, 16'h005A, 16'h0, 1'b0, 1'b0);
    data_op(1'b0, 1'b0, 1'b0, 16'h0802, 16'h0, {8'h5A, rw[7:0]}, 1'b0,
            1'b1);
    data_op(1'b0, 1'b1, 1'b0, 16'h0803, 16'h0, 16'h005A, 1'b0, 1'b1);
    data_op(1'b0, 1'b1, 1'b0, 16'h0802, 16'h0, {8'h00, rw[7:0]}, 1'b0,
            1'b1);
    data_op(1'b1, 1'b0, 1'b0, 16'h0806, 16'h1111, 16'h0, 1'b0, 1'b0);
    data_op(1'b1, 1'b0, 1'b0, 16'h0807, 16'h2222, 16'h0, 1'b1, 1'b0);
    data_op(1'b0, 1'b0, 1'b0, 16'h0807, 16'h0, 16'h0, 1'b1, 1'b0);
    data_op(1'b0, 1'b0, 1'b1, 16'h2806, 16'h0, 16'h1111, 1'b0, 1'b1);
    data_op(1'b1, 1'b0, 1'b0, 16'h4800, rw, 16'h0, 1'b0, 1'b0);
    data_op(1'b0, 1'b0, 1'b0, 16'h4800, 16'h0, 16'h0, 1'b0, 1'b1);
    data_op(1'b0, 1'b0, 1'b0, 16'h8010, 16'h0, 16'h0F1F, 1'b0, 1'b1);
    data_op(1'b0, 1'b0, 1'b0, 16'h0204, 16'h0, 16'hC1C7, 1'b0, 1'b1);
    data_op(1'b0, 1'b0, 1'b0, 16'h0206, 16'h0, 16'h0, 1'b0, 1'b1);
    data_op(1'b1, 1'b1, 1'b0, 16'h0205, 16'h00A5, 16'h0, 1'b0, 1'b0);
    data_op(1'b1, 1'b1, 1'b0, 16'h0207, 16'h00A5, 16'h0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rw = $random(seed);
      data_op(1'b1, 1'b0, 1'b0, 16'h1000 + {3'b0, rw[12:1], 1'b0}, rw,
              16'h0, 1'b0, 1'b0);
      data_op(1'b0, 1'b0, 1'b0, 16'h1000 + {3'b0, rw[12:1], 1'b0}, 16'h0,
              rw, 1'b0, 1'b1);
    end
    @(negedge clk_i);
    {rd_req_i, wr_req_i} = '0;
    tbl_op(8'h00, 16'h0100, pm(24'h00_0100) & 16'hFFFF);
    tbl_op(8'h00, 16'h0101, {8'h00, pm(24'h00_0100) >> 16});
    tbl_op(8'h80, 16'h0004, pm(24'h80_0004) & 16'hFFFF);
    @(negedge clk_i);
    tbl_req_i = '0;
    wreg_old_i = 16'h12F3;
    wreg_byte_i = 8'h9C;
    wreg_byte_load_i = 1'b1;
    #1 check_val(wreg_new_o, 16'h129C);
    wreg_byte_load_i = 1'b0;
    wreg_op_i = PDAM_REG_SIGN_EXT;
    #1 check_val(wreg_new_o, 16'hFFF3);
    wreg_op_i = PDAM_REG_UPPER_CLR;
    #1 check_val(wreg_new_o, 16'h00F3);
    repeat (2) @(negedge clk_i);
    // Second reset with the pointer away from zero
    do_reset();
    stop_test();
  end
endmodule
